// >>> rtl/ext_bus_map.vh
// Purpose: constants of the external bus address phase master
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef EXT_BUS_MAP_VH
`define EXT_BUS_MAP_VH

// operand size codes on the request port
`define SIZE_BYTE    2'h0
`define SIZE_HALF    2'h1
`define SIZE_WORD    2'h2

// data beats of an uninhibited burst and of a single transfer
`define BURST_BEATS  3'h4
`define ONE_BEAT     3'h1

// address step between decomposed cycles
`define STEP_WORD    32'h00000004
`define STEP_HALF    32'h00000002

// number of bus inputs passed through the synchroniser
`define SYNC_WIDTH   7
// level of a negated active-low pin
`define PIN_NEGATED  1'b1

`endif

// >>> rtl/pin_sync.v
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: one clock, synchronous active-high reset
// Notes:   reset loads a constant level into both stages
`timescale 1ns/1ns
module pin_sync
#(
   parameter       WIDTH     = 7,
   parameter [0:0] RESET_VAL = 1'b1
)
(
   clock,
   rst,
   pins,
   synced
);
   input  wire             clock;
   input  wire             rst;
   input  wire [WIDTH-1:0] pins;
   output wire [WIDTH-1:0] synced;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         reg meta_q;
         reg sync_q;
         always @(posedge clock)
         begin
            if (rst)
            begin
               meta_q <= RESET_VAL;
               sync_q <= RESET_VAL;
            end
            else
            begin
               meta_q <= pins[i];
               sync_q <= meta_q;
            end
         end
         assign synced[i] = sync_q;
      end
   endgenerate
endmodule

// >>> rtl/ext_bus_address_phase.v
// Purpose: address phase master of an external bus interface
// Assumes: one 20 MHz bus clock; pin inputs are active low and resynchronised
// Notes:   address and attributes are flops; pins float through their enables
// Operation
// RULE1: drive 30-bit word address, lanes carry low bit
// RULE2: 16-bit port: third lane carries half-word bit
// RULE3: address, busy, start one cycle after grant; here three cycles after the grant pin, as grant is resynchronised
// RULE4: float address and attributes with busy release
// RULE5: direction high for read, low write
// RULE6: attributes update only at address phase start
// RULE7: slaves ignore direction during pipelined data
// RULE8: burst stays asserted on decomposed single cycles
// RULE9: 32-bit port: four lanes enable four bytes
// RULE10: 16-bit port: two enables, fourth gives size
// RULE11: start strobe with busy, lasts one cycle
// RULE12: slave acknowledges end of address phase
// RULE13: OR internal and external acknowledge, internal stays inside
// RULE14: hold address and attributes until acknowledged
// RULE15: slave acknowledges no earlier than after start
// RULE16: slave acknowledges address no later than data
// RULE17: early acknowledge lets next cycle pipeline
// RULE18: slave acknowledge is a one-cycle pulse
// RULE19: start only with grant and bus not busy
// RULE20: phase ends by acknowledge, retry or error
// RULE21: sample inputs and register outputs on bus clock
`timescale 1ns/1ns
`include "ext_bus_map.vh"
module ext_bus_address_phase
(
   clock,
   rst,
   req_valid,
   req_ready,
   req_addr,
   req_read,
   req_size,
   req_burst,
   req_port16,
   cs_address_done,
   bus_grant_n,
   bus_busy_in_n,
   bus_busy_out_n,
   bus_busy_oe,
   address_phase_done_n,
   transfer_ack_n,
   transfer_error_ack_n,
   address_retry_in_n,
   burst_inhibit_n,
   address_out,
   read_not_write,
   burst_n,
   byte_lane_selects_n,
   transfer_start_n,
   pins_oe,
   phase_acked,
   phase_retried,
   bus_error
);
   input  wire        clock;
   input  wire        rst;
   input  wire        req_valid;
   output wire        req_ready;
   input  wire [31:0] req_addr;
   input  wire        req_read;
   input  wire [1:0]  req_size;
   input  wire        req_burst;
   input  wire        req_port16;
   input  wire        cs_address_done;
   input  wire        bus_grant_n;
   input  wire        bus_busy_in_n;
   output wire        bus_busy_out_n;
   output wire        bus_busy_oe;
   input  wire        address_phase_done_n;
   input  wire        transfer_ack_n;
   input  wire        transfer_error_ack_n;
   input  wire        address_retry_in_n;
   input  wire        burst_inhibit_n;
   output wire [29:0] address_out;
   output wire        read_not_write;
   output wire        burst_n;
   output wire [3:0]  byte_lane_selects_n;
   output wire        transfer_start_n;
   output wire        pins_oe;
   output wire        phase_acked;
   output wire        phase_retried;
   output wire        bus_error;

   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_ADDR = 2'h1;
   localparam [1:0] ST_DATA = 2'h2;
   localparam [1:0] ST_REL  = 2'h3;

   wire [`SYNC_WIDTH-1:0] synced;

   pin_sync
   #(
      .WIDTH     (`SYNC_WIDTH),
      .RESET_VAL (`PIN_NEGATED)
   )
   u_sync
   (
      .clock  (clock),
      .rst    (rst),
      .pins   ({bus_grant_n, bus_busy_in_n, address_phase_done_n, transfer_ack_n,
                transfer_error_ack_n, address_retry_in_n, burst_inhibit_n}),
      .synced (synced)
   );

   wire grant      = ~synced[6];
   wire other_busy = ~synced[5];
   wire ack_ext    = ~synced[4];
   wire beat_ack   = ~synced[3];
   wire beat_err   = ~synced[2];
   wire retry      = ~synced[1];
   wire binh       = ~synced[0];

   reg [1:0]  state_q;
   reg        drive_q;
   reg        strobe_q;
   reg        busy_oe_q;
   reg        busy_n_q;
   reg [31:0] addr_q;
   reg        read_q;
   reg [1:0]  size_q;
   reg        burst_q;
   reg        port16_q;
   reg [3:0]  lanes_q;
   reg [2:0]  parts_q;
   reg        was_inh_q;
   reg        redo_q;
   reg [1:0]  dp_cnt_q;
   reg [2:0]  head_q;
   reg [2:0]  tail_q;
   reg        acked_q;
   reg        retried_q;
   reg        error_q;

   // pin levels of the four lanes for one access
   function [3:0] lane_pins;
      input [1:0] a;
      input [1:0] size;
      input       p16;
      reg   [3:0] en;
      begin
         en = 4'h0;
         if (p16)
         begin
            if (size == `SIZE_BYTE)
               en[1:0] = a[0] ? 2'h2 : 2'h1;
            else
               en[1:0] = 2'h3;
            lane_pins = {(size != `SIZE_WORD), a[1], ~en[1], ~en[0]}; // RULE2 RULE10
         end
         else
         begin
            if (size == `SIZE_WORD)
               en = 4'hf;
            else if (size == `SIZE_HALF)
               en = a[1] ? 4'hc : 4'h3;
            else
               en = 4'h1 << a;
            lane_pins = ~en; // RULE9
         end
      end
   endfunction

   // internal chip-select acknowledge only joins here, never the pins
   wire phase_done = ack_ext | cs_address_done; // RULE13

   wire have_work = redo_q | (parts_q != 3'h0) | req_valid;
   wire can_go    = grant &
                    (((state_q == ST_IDLE) & ~other_busy) | // RULE19
                     ((state_q == ST_DATA) & (dp_cnt_q <= 2'h1))); // RULE17
   wire start     = have_work & can_go;
   wire take_new  = start & ~redo_q & (parts_q == 3'h0);

   assign req_ready = take_new;

   wire [31:0] step      = port16_q ? `STEP_HALF : `STEP_WORD;
   wire [31:0] next_addr = addr_q + step;

   // address phase events are ignored in the start cycle itself
   wire in_addr   = (state_q == ST_ADDR) & ~strobe_q;
   wire ev_retry  = in_addr & retry; // RULE20
   wire ev_abort  = in_addr & ~retry & beat_err & (dp_cnt_q == 2'h0);
   wire push      = in_addr & ~retry & ~(beat_err & (dp_cnt_q == 2'h0)) & phase_done;
   wire [2:0] push_beats = (burst_q & ~binh & ~was_inh_q) ? `BURST_BEATS : `ONE_BEAT;
   wire pop       = (dp_cnt_q != 2'h0) & (beat_err | (beat_ack & (head_q == 3'h1)));

   // bus tenure and address phase sequencing
   always @(posedge clock)
   begin
      if (rst)
      begin
         state_q   <= ST_IDLE;
         drive_q   <= 1'b0;
         strobe_q  <= 1'b0;
         busy_oe_q <= 1'b0;
         busy_n_q  <= 1'b1;
      end
      else
      begin
         strobe_q <= start; // RULE11
         case (state_q)
            ST_IDLE:
            begin
               busy_oe_q <= 1'b0;
               if (start)
               begin
                  state_q   <= ST_ADDR;
                  drive_q   <= 1'b1; // RULE3
                  busy_oe_q <= 1'b1;
                  busy_n_q  <= 1'b0;
               end
            end
            ST_ADDR:
            begin
               // stay driven until the phase is ended
               if (ev_retry)
                  state_q <= (dp_cnt_q != 2'h0) ? ST_DATA : ST_REL; // RULE14
               else if (ev_abort)
                  state_q <= ST_REL;
               else if (push)
                  state_q <= ST_DATA;
               if ((ev_retry & (dp_cnt_q == 2'h0)) | ev_abort)
               begin
                  drive_q  <= 1'b0; // RULE4
                  busy_n_q <= 1'b1;
               end
            end
            ST_DATA:
            begin
               if (start)
                  state_q <= ST_ADDR;
               else if (dp_cnt_q == 2'h0)
               begin
                  state_q  <= ST_REL;
                  drive_q  <= 1'b0; // RULE4
                  busy_n_q <= 1'b1;
               end
            end
            ST_REL:
            begin
               // busy driven high one cycle, then floated
               state_q   <= ST_IDLE;
               busy_oe_q <= 1'b0;
            end
            default:
            begin
               state_q   <= ST_IDLE;
               drive_q   <= 1'b0;
               busy_oe_q <= 1'b0;
               busy_n_q  <= 1'b1;
            end
         endcase
      end
   end

   // address and attributes change only when a phase starts
   always @(posedge clock)
   begin
      if (rst)
      begin
         addr_q    <= 32'h00000000;
         read_q    <= 1'b0;
         size_q    <= `SIZE_WORD;
         burst_q   <= 1'b0;
         port16_q  <= 1'b0;
         lanes_q   <= 4'hf;
         parts_q   <= 3'h0;
         was_inh_q <= 1'b0;
         redo_q    <= 1'b0;
      end
      else
      begin
         if (take_new)
         begin
            addr_q    <= req_addr; // RULE1 RULE6
            read_q    <= req_read; // RULE5
            size_q    <= req_size;
            burst_q   <= req_burst;
            port16_q  <= req_port16;
            lanes_q   <= lane_pins(req_addr[1:0], req_size, req_port16);
            parts_q   <= (req_port16 & (req_size == `SIZE_WORD)) ? 3'h1 : 3'h0;
            was_inh_q <= 1'b0;
         end
         else if (start & ~redo_q)
         begin
            // next piece of a split word or inhibited burst
            addr_q  <= next_addr;
            lanes_q <= lane_pins(next_addr[1:0], size_q, port16_q);
            parts_q <= parts_q - 3'h1;
         end
         else if (push & burst_q & binh & ~was_inh_q)
         begin
            // burst indicator kept for every decomposed cycle
            parts_q   <= `BURST_BEATS - 3'h1; // RULE8
            was_inh_q <= 1'b1;
         end
         else if (ev_abort | (pop & beat_err))
            parts_q <= 3'h0;
         if (ev_retry)
            redo_q <= 1'b1;
         else if (start)
            redo_q <= 1'b0;
      end
   end

   // outstanding data phases, at most one ahead of the current
   always @(posedge clock)
   begin
      if (rst)
      begin
         dp_cnt_q <= 2'h0;
         head_q   <= 3'h0;
         tail_q   <= 3'h0;
      end
      else
      begin
         if (pop)
            head_q <= (dp_cnt_q == 2'h2) ? tail_q : push_beats;
         else if ((dp_cnt_q != 2'h0) & beat_ack)
            head_q <= head_q - 3'h1;
         else if (push & (dp_cnt_q == 2'h0))
            head_q <= push_beats;
         if (push & (dp_cnt_q == 2'h1) & ~pop)
            tail_q <= push_beats;
         case ({push, pop})
            2'b10:   dp_cnt_q <= dp_cnt_q + 2'h1;
            2'b01:   dp_cnt_q <= dp_cnt_q - 2'h1;
            default: dp_cnt_q <= dp_cnt_q;
         endcase
      end
   end

   // one-cycle status pulses toward the user side
   always @(posedge clock)
   begin
      if (rst)
      begin
         acked_q   <= 1'b0;
         retried_q <= 1'b0;
         error_q   <= 1'b0;
      end
      else
      begin
         acked_q   <= push;
         retried_q <= ev_retry;
         error_q   <= ev_abort | (pop & beat_err);
      end
   end

   assign address_out         = addr_q[31:2]; // RULE21
   assign read_not_write      = read_q;
   assign burst_n             = ~burst_q;
   assign byte_lane_selects_n = lanes_q;
   assign transfer_start_n    = ~strobe_q;
   assign pins_oe             = drive_q;
   assign bus_busy_out_n      = busy_n_q;
   assign bus_busy_oe         = busy_oe_q;
   assign phase_acked         = acked_q;
   assign phase_retried       = retried_q;
   assign bus_error           = error_q;
endmodule

// >>> tb/ext_bus_address_phase_checker.sv
// Purpose: port checker for the address phase master
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into every instance of the top module
`timescale 1ns/1ns
module ext_bus_address_phase_checker
(
   input wire        clock,
   input wire        rst,
   input wire        req_valid,
   input wire        req_ready,
   input wire [31:0] req_addr,
   input wire        req_read,
   input wire        cs_address_done,
   input wire        bus_grant_n,
   input wire        bus_busy_in_n,
   input wire        bus_busy_out_n,
   input wire        bus_busy_oe,
   input wire [29:0] address_out,
   input wire        read_not_write,
   input wire        burst_n,
   input wire [3:0]  byte_lane_selects_n,
   input wire        transfer_start_n,
   input wire        pins_oe,
   input wire        phase_acked
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_take;
      req_valid && req_ready;
   endsequence
   sequence s_fresh_start;
      $fell(transfer_start_n) && !$past(bus_busy_oe);
   endsequence
   a_take_start: assert property (s_take |=> !transfer_start_n)
      else $error("no start after take");
   a_take_attrs: assert property (s_take |=> address_out == $past(req_addr[31:2])
      && read_not_write == $past(req_read))
      else $error("address or direction wrong");
   a_start_busy: assert property (!transfer_start_n |-> pins_oe && bus_busy_oe
      && !bus_busy_out_n)
      else $error("start without busy");
   a_start_pulse: assert property (!transfer_start_n |=> transfer_start_n)
      else $error("start longer than one cycle");
   a_attr_hold: assert property (pins_oe && transfer_start_n |->
      $stable({address_out, read_not_write, burst_n, byte_lane_selects_n}))
      else $error("attributes moved inside phase");
   a_float_busy: assert property (!bus_busy_oe |-> !pins_oe)
      else $error("pins driven without busy");
   a_grant_qual: assert property (s_fresh_start |->
      $past(!bus_grant_n, 3) && $past(bus_busy_in_n, 3))
      else $error("start without qualified grant");
   a_cs_ack: assert property (cs_address_done |-> ##[1:4] phase_acked)
      else $error("internal ack ignored");
endmodule
bind ext_bus_address_phase ext_bus_address_phase_checker chk_i
(
   .clock, .rst, .req_valid, .req_ready, .req_addr, .req_read, .cs_address_done,
   .bus_grant_n, .bus_busy_in_n, .bus_busy_out_n, .bus_busy_oe, .address_out,
   .read_not_write, .burst_n, .byte_lane_selects_n, .transfer_start_n, .pins_oe,
   .phase_acked
);

// >>> tb/bus_slave_model.sv
// Purpose: external slave answering address and data phases
// Assumes: pins are active low with pull-ups, negated when idle
// Notes:   ack_delay 0 leaves the address ack to the chip select
`timescale 1ns/1ns
module bus_slave_model
(
   input wire       clock,
   input wire       rst,
   input wire       transfer_start_n,
   input wire       burst_n,
   input wire [3:0] ack_delay,
   input wire       inhibit,
   input wire       err,
   output reg       address_phase_done_n,
   output reg       transfer_ack_n,
   output reg       transfer_error_ack_n,
   output reg       burst_inhibit_n
);
   integer pend[$];
   integer n;
   integer m;
   initial
   begin
      address_phase_done_n = 1'h1;
      transfer_ack_n = 1'h1;
      transfer_error_ack_n = 1'h1;
      burst_inhibit_n = 1'h1;
   end
   // address side: ack no earlier than the cycle after start, one cycle long
   always
   begin
      @(posedge clock);
      if (!rst && transfer_start_n === 1'h0)
      begin
         n = (burst_n === 1'h0 && !inhibit) ? 4 : 1;
         if (err)
            n = 0;
         if (ack_delay != 4'h0)
         begin
            repeat (ack_delay - 1) @(posedge clock);
            #2 address_phase_done_n = 1'h0;
            burst_inhibit_n = !inhibit;
            @(posedge clock);
            #2 address_phase_done_n = 1'h1;
            burst_inhibit_n = 1'h1;
         end
         pend.push_back(n);
      end
   end
   // data side: beats follow the address ack; direction is not read
   always
   begin
      @(posedge clock);
      if (pend.size() > 0)
      begin
         m = pend.pop_front();
         #2;
         if (m == 0)
         begin
            transfer_error_ack_n = 1'h0;
            @(posedge clock);
            #2;
         end
         repeat (m)
         begin
            transfer_ack_n = 1'h0;
            @(posedge clock);
            #2;
         end
         transfer_ack_n = 1'h1;
         transfer_error_ack_n = 1'h1;
      end
   end
endmodule

// >>> tb/ext_bus_address_phase_tb.sv
// Purpose: self-checking bench of the address phase master
// Assumes: 50 ns clock, inputs driven 2 ns after the rising edge
// Notes:   arbiter and other master are modelled inline
`timescale 1ns/1ns
module ext_bus_address_phase_tb;
   reg         clock, rst, req_valid, req_read, req_burst, req_port16;
   reg         cs_address_done, bus_grant_n, oth_n, inhibit, err;
   reg  [31:0] req_addr;
   reg  [1:0]  req_size;
   reg  [3:0]  ack_delay;
   wire        req_ready, bus_busy_out_n, bus_busy_oe, address_phase_done_n;
   wire        transfer_ack_n, transfer_error_ack_n, burst_inhibit_n, read_not_write;
   wire        burst_n, transfer_start_n, pins_oe, phase_acked, phase_retried, bus_error;
   wire [29:0] address_out;
   wire [3:0]  byte_lane_selects_n;
   reg         address_retry_in_n;
   wire        bus_busy_in_n = bus_busy_oe ? bus_busy_out_n : oth_n;
   integer     n_fail, check_count, cyc, n_start, n_bst, i, s0, b0;
   reg  [29:0] last_a;
   reg  [16:0] tbl [0:7];
   ext_bus_address_phase uut
   (
      .clock, .rst, .req_valid, .req_ready, .req_addr, .req_read, .req_size, .req_burst,
      .req_port16, .cs_address_done, .bus_grant_n, .bus_busy_in_n, .bus_busy_out_n,
      .bus_busy_oe, .address_phase_done_n, .transfer_ack_n, .transfer_error_ack_n,
      .address_retry_in_n, .burst_inhibit_n, .address_out, .read_not_write, .burst_n,
      .byte_lane_selects_n, .transfer_start_n, .pins_oe, .phase_acked, .phase_retried,
      .bus_error
   );
   bus_slave_model slave
   (
      .clock, .rst, .transfer_start_n, .burst_n, .ack_delay, .inhibit, .err,
      .address_phase_done_n, .transfer_ack_n, .transfer_error_ack_n, .burst_inhibit_n
   );
   initial
   begin
      clock = 1'h0;
      forever #25 clock = !clock;
   end
   always @(negedge clock)
      if (transfer_start_n === 1'h0)
      begin
         n_start = n_start + 1;
         if (burst_n === 1'h0)
            n_bst = n_bst + 1;
         last_a = address_out;
      end
   always @(posedge clock)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         n_fail = n_fail + 1;
         print_verdict;
      end
   end
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", check_count, n_fail);
         if (n_fail == 0 && check_count > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp)
         begin
            n_fail = n_fail + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task go(input [31:0] a, input rd, input [1:0] sz, input b, input p, input [3:0] ln);
      integer k;
      begin
         req_addr = a;
         req_read = rd;
         req_size = sz;
         req_burst = b;
         req_port16 = p;
         req_valid = 1'h1;
         k = 0;
         @(negedge clock);
         while (k < 60 && req_ready !== 1'h1)
         begin
            @(negedge clock);
            k = k + 1;
         end
         chk(req_ready, 1);
         @(posedge clock);
         #2 req_valid = 1'h0;
         chk(transfer_start_n, 0);
         chk(address_out, a[31:2]);
         chk(read_not_write, rd);
         chk(burst_n, !b);
         chk(byte_lane_selects_n, ln);
      end
   endtask
   task wait_for(input integer n);
      integer k;
      begin
         for (k = 0; k < 100 && n_start < n; k = k + 1)
            @(negedge clock);
      end
   endtask
   task idle;
      integer k;
      begin
         @(negedge clock);
         for (k = 0; k < 80 && bus_busy_oe !== 1'h0; k = k + 1)
            @(negedge clock);
         chk(bus_busy_oe, 0);
         repeat (4) @(posedge clock);
         #2;
      end
   endtask
   initial
   begin
      {rst, bus_grant_n, oth_n, ack_delay} = {3'h7, 4'h1};
      address_retry_in_n = 1'h1;
      {req_valid, req_read, req_burst, req_port16, cs_address_done, inhibit, err} = 7'h0;
      {req_addr, req_size} = 34'h0;
      {n_fail, check_count, cyc, n_start, n_bst} = 160'h0;
      tbl[0] = {8'h00, 1'h1, 2'h2, 1'h0, 1'h0, 4'h0};
      tbl[1] = {8'h02, 1'h0, 2'h1, 1'h0, 1'h0, 4'h3};
      tbl[2] = {8'h01, 1'h1, 2'h0, 1'h0, 1'h0, 4'hd};
      tbl[3] = {8'h07, 1'h0, 2'h0, 1'h0, 1'h0, 4'h7};
      tbl[4] = {8'h10, 1'h1, 2'h2, 1'h1, 1'h0, 4'h0};
      tbl[5] = {8'h22, 1'h1, 2'h1, 1'h0, 1'h1, 4'hc};
      tbl[6] = {8'h31, 1'h0, 2'h0, 1'h0, 1'h1, 4'h9};
      tbl[7] = {8'h42, 1'h1, 2'h0, 1'h0, 1'h1, 4'he};
      repeat (8) @(posedge clock);
      #2 rst = 1'h0;
      chk({pins_oe, bus_busy_oe, transfer_start_n, byte_lane_selects_n}, 32'h1f);
      // no grant, then grant while another master holds busy
      {req_valid, req_read, req_addr, req_size} = {1'h1, 1'h1, 32'h2000, 2'h2};
      repeat (10) @(posedge clock);
      #2 {bus_grant_n, oth_n} = 2'h0;
      repeat (10) @(posedge clock);
      chk(n_start, 0);
      #2 oth_n = 1'h1;
      go(32'h2000, 1, 2'h2, 0, 0, 4'h0);
      idle;
      for (i = 0; i < 8; i = i + 1)
      begin
         go({24'h10, tbl[i][16:9]}, tbl[i][8], tbl[i][7:6], tbl[i][5], tbl[i][4], tbl[i][3:0]);
         idle;
      end
      // word to a 16-bit port goes out as two halves under one busy
      s0 = n_start;
      go(32'h1060, 1, 2'h2, 0, 1, 4'h0);
      wait_for(s0 + 2);
      chk(byte_lane_selects_n, 4'h4);
      chk(address_out, 30'h418);
      chk(bus_busy_oe, 1);
      idle;
      {inhibit, s0, b0} = {1'h1, n_start, n_bst};
      go(32'h1080, 1, 2'h2, 1, 0, 4'h0);
      wait_for(s0 + 4);
      idle;
      chk(n_start - s0, 4);
      chk(n_bst - b0, 4);
      chk(last_a, 30'h423);
      {inhibit, ack_delay} = 5'h0;
      go(32'h10a0, 0, 2'h2, 0, 0, 4'h0);
      @(posedge clock);
      #2 cs_address_done = 1'h1;
      @(posedge clock);
      #2 cs_address_done = 1'h0;
      for (i = 0; i < 12 && phase_acked !== 1'h1; i = i + 1)
         @(negedge clock);
      chk(phase_acked, 1);
      idle;
      {ack_delay, err} = {4'h1, 1'h1};
      go(32'h10c0, 1, 2'h2, 0, 0, 4'h0);
      for (i = 0; i < 12 && bus_error !== 1'h1; i = i + 1)
         @(negedge clock);
      chk(bus_error, 1);
      idle;
      // burst then a request at once: second start overlaps the data beats
      {err, s0} = {1'h0, n_start};
      go(32'h1100, 1, 2'h2, 1, 0, 4'h0);
      @(posedge clock);
      #2;
      go(32'h1200, 0, 2'h2, 0, 0, 4'h0);
      chk(transfer_ack_n === 1'h0 || n_start - s0 == 2, 1);
      idle;
      // retry with no ack: pins released, same request goes out again
      {ack_delay, s0} = {4'h0, n_start};
      go(32'h1300, 1, 2'h2, 0, 0, 4'h0);
      @(posedge clock);
      #2 address_retry_in_n = 1'h0;
      @(posedge clock);
      #2 {address_retry_in_n, ack_delay} = 5'h11;
      for (i = 0; i < 12 && phase_retried !== 1'h1; i = i + 1)
         @(negedge clock);
      chk(phase_retried, 1);
      wait_for(s0 + 2);
      chk(n_start - s0, 2);
      chk(last_a, 30'h4c0);
      idle;
      // reset from idle puts the pin and busy enables, start strobe and lane selects back to their reset levels
      rst = 1'h1;
      repeat (2) @(posedge clock);
      #2 rst = 1'h0;
      chk({pins_oe, bus_busy_oe, transfer_start_n, byte_lane_selects_n}, 32'h1f);
      print_verdict;
   end
endmodule
